/* File: system_clock_prescaler.sv */
// system clock prescaler, clock output pin, pll lock and watchdog tick
//
// Contract
// R1: lock flag rises only after pll enabled for the lock time, then fast clock.
// R2: provide a 128 kHz tick as the watchdog timebase.
// R3: external clock source used only when source fuses read 0000.
// R4: wake delay 6 clocks; reset delay 14 clocks plus fuse-selected extra.
// R5: external clock must not jump over 2% per cycle outside reset.
// R6: clock-output fuse drives system clock on pin, also in reset; in reset the code enables the pin but drives it low.
// R7: pin clock is taken after the divider.
// R8: one divided enable feeds cpu, io, converter and flash domains.
// R9: select codes 0..8 divide by 2^code; 9..15 reserved.
// R10: factor changes without glitches or short periods.
// R11: new factor active after old period plus one to two new.
// R12: divider counts on master clock and its count is not readable.
// R13: unlock bit set only by writing it with all other bits zero.
// R14: software writes select within four cycles after unlocking.
// R15: unlock clears four cycles after set or on a select write.
// R16: rewriting unlock inside the window neither restarts nor clears it.
// R17: software keeps interrupts off during the unlock sequence.
// R18: select resets to 0000, or 0011 with divide-by-eight fuse.
// R19: any select value accepted through the unlock sequence.
// R20: select writes without unlock are ignored.
// R21: divider register bits 6..4 read zero and ignore writes.
`timescale 1ns/1ps
`include "prescaler_regs.svh"
module system_clock_prescaler #(
  parameter int PLL_LOCK_CYCLES = `PLL_LOCK_CYCLES,
  parameter int SUT_FAST_CYCLES = `SUT_FAST_CYCLES,
  parameter int SUT_SLOW_CYCLES = `SUT_SLOW_CYCLES
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // register port
  input wire logic [7:0] addr_in,
  input wire prescaler_pkg::reg_byte_t wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output prescaler_pkg::reg_byte_t rdata_out,
  // fuses, high means programmed
  input wire logic [3:0] clock_source_fuses_in,
  input wire prescaler_pkg::startup_code_t startup_time_fuses_in,
  input wire logic start_divide_by_eight_fuse_in,
  input wire logic clock_output_fuse_in,
  // wake request from the sleep logic
  input wire logic wake_request_in,
  // normal i/o function of the clock output pin
  input wire logic gpio_data_in,
  input wire logic gpio_oe_in,
  // clock output pin
  output logic clock_out_pin_out,
  output logic clock_out_pin_oe_out,
  // clock domains and status
  output logic sys_clock_enable_out,
  output logic ext_clock_selected_out,
  output logic system_ready_out,
  output logic wake_ready_out,
  output logic pll_locked_flag_out,
  output logic fast_clock_enable_out,
  output logic watchdog_tick_out
);
  import prescaler_pkg::*;

  prescale_if pif ();

  unlock_state_t unl_r, unl_nxt;
  logic [1:0] ucnt_r, ucnt_nxt;
  div_sel_t sel_r, sel_nxt;
  logic load_r, load_nxt;
  logic pll_en_r, pll_en_nxt;
  logic fast_r, fast_nxt;
  reg_byte_t rdata_r, rdata_nxt;
  logic pin_r, pin_nxt;
  logic pin_oe_r, pin_oe_nxt;
  logic en_out_r, ext_r, ready_r, wake_r, lock_r, tick_r;
  logic wake_pend_r, wake_pend_nxt;
  logic div_wr;
  logic lock_done, start_done, wake_done, tick_done;
  logic [`TIMER_W-1:0] start_limit;

  // divider core
  clock_divider_core u_core (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .pif(pif.core)
  );

  assign pif.sel_req = sel_r;
  assign pif.load = load_r;

  // pll lock timer runs while the pll is enabled
  cycle_timer u_lock (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .run_in(pll_en_r),
    .periodic_in(1'b0),
    .limit_in(`TIMER_W'(PLL_LOCK_CYCLES)),
    .done_out(lock_done)
  );

  // reset delay: 14 clocks plus the startup fuse extra
  always_comb begin
    unique case (startup_time_fuses_in) // R4
      SUT_SHORT: start_limit = `TIMER_W'(`RESET_BASE_CK);
      SUT_FAST: start_limit = `TIMER_W'(`RESET_BASE_CK + SUT_FAST_CYCLES);
      SUT_SLOW: start_limit = `TIMER_W'(`RESET_BASE_CK + SUT_SLOW_CYCLES);
      SUT_RESV: start_limit = `TIMER_W'(`RESET_BASE_CK + SUT_SLOW_CYCLES);
    endcase
  end

  cycle_timer u_start (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .run_in(1'b1),
    .periodic_in(1'b0),
    .limit_in(start_limit),
    .done_out(start_done)
  );

  // wake-up delay of 6 clocks
  cycle_timer u_wake (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .run_in(wake_pend_r),
    .periodic_in(1'b0),
    .limit_in(`TIMER_W'(`WAKE_CK - 1)),
    .done_out(wake_done)
  );

  // 128 kHz tick for the watchdog, counted on the master clock
  cycle_timer u_wdog (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .run_in(1'b1),
    .periodic_in(1'b1),
    .limit_in(`TIMER_W'(`WDOG_TICK_CYCLES - 1)),
    .done_out(tick_done)
  );

  // unlock window and divider select update
  always_comb begin
    div_wr = wr_in && (addr_in == `DIV_REG_ADDR);
    unl_nxt = unl_r;
    ucnt_nxt = ucnt_r;
    sel_nxt = sel_r;
    load_nxt = 1'b0;
    unique case (unl_r)
      UNL_IDLE: begin
        if (div_wr && (wdata_in == `UNLOCK_WORD)) begin // R13
          unl_nxt = UNL_OPEN;
          ucnt_nxt = 2'h0;
        end
      end
      UNL_OPEN: begin
        if (div_wr && !wdata_in[`UNLOCK_BIT]) begin
          sel_nxt = wdata_in[`SEL_MSB:0]; // R19 R21
          load_nxt = 1'b1;
          unl_nxt = UNL_IDLE; // R15
        end else if (ucnt_r == `UNLOCK_LAST) begin
          unl_nxt = UNL_IDLE; // R15 R16
        end else begin
          ucnt_nxt = ucnt_r + 2'h1;
        end
      end
    endcase
  end

  // pll control, fast clock gated by lock, wake request
  always_comb begin
    pll_en_nxt = pll_en_r;
    fast_nxt = fast_r;
    if (wr_in && (addr_in == `PLL_REG_ADDR)) begin
      pll_en_nxt = wdata_in[`PLL_EN_BIT];
      fast_nxt = wdata_in[`FAST_EN_BIT] && lock_done; // R1
    end
    // drop the fast clock once the pll is off, no later than lock falls
    if (!lock_done || !pll_en_r) begin
      fast_nxt = 1'b0; // R1
    end
    wake_pend_nxt = wake_pend_r;
    if (wake_request_in) begin
      wake_pend_nxt = 1'b1;
    end else if (wake_done) begin
      wake_pend_nxt = 1'b0;
    end
  end

  // read data and pin drive
  always_comb begin
    rdata_nxt = 8'h00;
    if (rd_in && (addr_in == `DIV_REG_ADDR)) begin
      rdata_nxt[`UNLOCK_BIT] = (unl_r == UNL_OPEN);
      rdata_nxt[`SEL_MSB:0] = sel_r; // R21
    end else if (rd_in && (addr_in == `PLL_REG_ADDR)) begin
      rdata_nxt[`PLL_LOCK_BIT] = lock_done;
      rdata_nxt[`PLL_EN_BIT] = pll_en_r;
      rdata_nxt[`FAST_EN_BIT] = fast_r;
    end
    if (clock_output_fuse_in) begin
      pin_nxt = pif.clk_level; // R6 R7
      pin_oe_nxt = 1'b1; // R6
    end else begin
      pin_nxt = gpio_data_in;
      pin_oe_nxt = gpio_oe_in;
    end
  end

  // control registers, select reset follows the divide-by-eight fuse
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      unl_r <= UNL_IDLE;
      ucnt_r <= 2'h0;
      sel_r <= start_divide_by_eight_fuse_in ? `SEL_DIV8 : `SEL_DIV1; // R18
      load_r <= 1'b0;
      pll_en_r <= 1'b0;
      fast_r <= 1'b0;
      wake_pend_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      unl_r <= unl_nxt;
      ucnt_r <= ucnt_nxt;
      sel_r <= sel_nxt; // R20
      load_r <= load_nxt;
      pll_en_r <= pll_en_nxt;
      fast_r <= fast_nxt;
      wake_pend_r <= wake_pend_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // output flops; in reset the pin is enabled only with the clock-output fuse, and is driven low
  always_ff @(posedge mclk_in) begin
    pin_r <= reset_in ? 1'b0 : pin_nxt;
    pin_oe_r <= reset_in ? clock_output_fuse_in : pin_oe_nxt; // R6
    if (reset_in) begin
      en_out_r <= 1'b0;
      ext_r <= 1'b0;
      ready_r <= 1'b0;
      wake_r <= 1'b0;
      lock_r <= 1'b0;
      tick_r <= 1'b0;
    end else begin
      en_out_r <= pif.sys_en; // R8
      ext_r <= (clock_source_fuses_in == `EXT_CLK_CODE); // R3
      ready_r <= start_done; // R4
      wake_r <= wake_done && wake_pend_r; // R4
      lock_r <= lock_done; // R1
      tick_r <= tick_done; // R2
    end
  end

  assign rdata_out = rdata_r;
  assign clock_out_pin_out = pin_r;
  assign clock_out_pin_oe_out = pin_oe_r;
  assign sys_clock_enable_out = en_out_r;
  assign ext_clock_selected_out = ext_r;
  assign system_ready_out = ready_r;
  assign wake_ready_out = wake_r;
  assign pll_locked_flag_out = lock_r;
  assign fast_clock_enable_out = fast_r;
  assign watchdog_tick_out = tick_r;

  unlock_set_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    div_wr && (wdata_in == `UNLOCK_WORD) && (unl_r == UNL_IDLE)
    |=> (unl_r == UNL_OPEN)) else $error("unlock not set"); // R13
  unlock_bad_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    div_wr && wdata_in[`UNLOCK_BIT] && (wdata_in[6:0] != 7'h00)
    && (unl_r == UNL_IDLE) |=> (unl_r == UNL_IDLE))
    else $error("unlock set by dirty write"); // R13
  unlock_timeout_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    $rose(unl_r) |-> ##4 (unl_r == UNL_IDLE))
    else $error("unlock window not four cycles"); // R15
  no_restart_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    (unl_r == UNL_OPEN) && (ucnt_r == 2'h1) && div_wr
    && (wdata_in == `UNLOCK_WORD) |=> (unl_r == UNL_OPEN) ##2
    (unl_r == UNL_IDLE)) else $error("rewrite changed window"); // R16
  sel_load_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    div_wr && (unl_r == UNL_OPEN) && !wdata_in[`UNLOCK_BIT]
    |=> (sel_r == $past(wdata_in[3:0])) && (unl_r == UNL_IDLE))
    else $error("select not loaded"); // R19
  sel_locked_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    (unl_r == UNL_IDLE) |=> $stable(sel_r))
    else $error("select changed while locked"); // R20
  rsvd_zero_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    rd_in && (addr_in == `DIV_REG_ADDR) |=> (rdata_out[6:4] == 3'h0))
    else $error("reserved bits not zero"); // R21
  pin_drive_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    clock_output_fuse_in ##1 clock_output_fuse_in |->
    clock_out_pin_oe_out && (clock_out_pin_out == $past(pif.clk_level)))
    else $error("clock not on pin"); // R6
  ext_sel_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    ##1 ext_clock_selected_out == ($past(clock_source_fuses_in) == 4'h0))
    else $error("external source decode wrong"); // R3
  fast_gate_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    fast_clock_enable_out |-> lock_done)
    else $error("fast clock without lock"); // R1
endmodule

/* File: prescaler_regs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef PRESCALER_REGS_SVH
`define PRESCALER_REGS_SVH

// register offsets
`define DIV_REG_ADDR 8'h00
`define PLL_REG_ADDR 8'h01

// divider register fields
`define UNLOCK_BIT 7
`define SEL_MSB 3
`define RSVD_MSB 6
`define RSVD_LSB 4
`define UNLOCK_WORD 8'h80
`define SEL_DIV1 4'h0
`define SEL_DIV8 4'h3
`define SEL_MAX 4'h8
`define UNLOCK_LAST 2'h3

// pll register fields
`define PLL_LOCK_BIT 0
`define PLL_EN_BIT 1
`define FAST_EN_BIT 2

// clock source code for the external clock input
`define EXT_CLK_CODE 4'h0

// timing figures and derived cycle counts at the master clock rate
`define MCLK_KHZ 250000
`define PLL_LOCK_MS 100
`define PLL_LOCK_CYCLES (`PLL_LOCK_MS * `MCLK_KHZ)
`define WDOG_OSC_KHZ 128
`define WDOG_TICK_CYCLES (`MCLK_KHZ / `WDOG_OSC_KHZ)
`define RESET_BASE_CK 14
`define WAKE_CK 6
`define SUT_FAST_US 4100
`define SUT_SLOW_US 65000
`define SUT_FAST_CYCLES (`SUT_FAST_US * (`MCLK_KHZ / 1000))
`define SUT_SLOW_CYCLES (`SUT_SLOW_US * (`MCLK_KHZ / 1000))
`define TIMER_W 26
`define DIV_CNT_W 8

`endif

/* File: prescaler_pkg.sv */
// types shared by the clock prescaler modules
package prescaler_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [3:0] div_sel_t;
  typedef enum logic {
    UNL_IDLE = 1'b0,
    UNL_OPEN = 1'b1
  } unlock_state_t;
  typedef enum logic [1:0] {
    SUT_SHORT = 2'b00,
    SUT_FAST = 2'b01,
    SUT_SLOW = 2'b10,
    SUT_RESV = 2'b11
  } startup_code_t;
endpackage

/* File: prescale_if.sv */
// link between the register logic and the divider core
`timescale 1ns/1ps
interface prescale_if;
  import prescaler_pkg::*;
  div_sel_t sel_req;
  logic load;
  logic sys_en;
  logic clk_level;
  div_sel_t cur_sel;
  modport core (input sel_req, input load,
    output sys_en, output clk_level, output cur_sel);
  modport ctrl (output sel_req, output load,
    input sys_en, input clk_level, input cur_sel);
endinterface

/* File: cycle_timer.sv */
// run-gated cycle counter, one-shot or periodic
`timescale 1ns/1ps
`include "prescaler_regs.svh"
module cycle_timer (
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // control
  input wire logic run_in,
  input wire logic periodic_in,
  input wire logic [`TIMER_W-1:0] limit_in,
  // status
  output logic done_out
);
  logic [`TIMER_W-1:0] cnt_r, cnt_nxt;
  logic done_r, done_nxt;

  // count while run is high, flag when the limit is reached
  always_comb begin
    cnt_nxt = cnt_r;
    done_nxt = done_r;
    if (!run_in) begin
      cnt_nxt = '0;
      done_nxt = 1'b0;
    end else if (cnt_r == limit_in) begin
      done_nxt = 1'b1;
      if (periodic_in) begin
        cnt_nxt = '0;
      end
    end else begin
      cnt_nxt = cnt_r + 1'b1;
      if (periodic_in) begin
        done_nxt = 1'b0;
      end
    end
  end

  // state registers
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      cnt_r <= '0;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign done_out = done_r;
endmodule

/* File: clock_divider_core.sv */
// power-of-two divider on the master clock with glitch-free switching
`timescale 1ns/1ps
`include "prescaler_regs.svh"
module clock_divider_core (
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // link to the register logic
  prescale_if.core pif
);
  import prescaler_pkg::*;

  logic [`DIV_CNT_W-1:0] cnt_r, cnt_nxt;
  div_sel_t cur_r, cur_nxt;
  logic pend_r, pend_nxt;
  logic en_r, en_nxt;
  logic lvl_r, lvl_nxt;
  logic [`DIV_CNT_W:0] mask_full;
  logic [`DIV_CNT_W-1:0] mask;
  logic term;
  logic [2:0] idx;

  // terminal count of the running setting; reserved codes act as 256
  always_comb begin
    mask_full = (9'h001 << cur_r) - 9'h001; // R9
    mask = mask_full[`DIV_CNT_W-1:0];
    term = ((cnt_r & mask) == mask);
    cnt_nxt = cnt_r + 1'b1;
    cur_nxt = cur_r;
    pend_nxt = pend_r;
    en_nxt = term;
    // new factor only at a period boundary, then a full new period
    if (term && (pend_r || pif.load)) begin // R10 R11
      cur_nxt = (pif.sel_req > `SEL_MAX) ? `SEL_MAX : pif.sel_req;
      cnt_nxt = '0;
      pend_nxt = 1'b0;
    end else if (pif.load) begin
      pend_nxt = 1'b1;
    end
    idx = 3'(cur_nxt - 4'h1);
    if (cur_nxt == `SEL_DIV1) begin
      lvl_nxt = ~lvl_r;
    end else begin
      lvl_nxt = cnt_nxt[idx];
    end
  end

  // ripple-style count kept as one synchronous counter on mclk
  always_ff @(posedge mclk_in) begin // R12
    if (reset_in) begin
      cnt_r <= '0;
      cur_r <= (pif.sel_req > `SEL_MAX) ? `SEL_MAX : pif.sel_req;
      pend_r <= 1'b0;
      en_r <= 1'b0;
      lvl_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      cur_r <= cur_nxt;
      pend_r <= pend_nxt;
      en_r <= en_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  assign pif.sys_en = en_r;
  assign pif.clk_level = lvl_r;
  assign pif.cur_sel = cur_r;

  // factor only changes where the old period ends
  switch_edge_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    $changed(cur_r) |-> $past(term)) else $error("divider switched mid-period"); // R10
  // a pending change lands within one longest old period
  switch_time_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    $rose(pend_r) |-> ##[1:256] !pend_r) else $error("divider change stuck"); // R11
endmodule

/* File: system_clock_prescaler_tb.sv */
// self-checking bench for the system clock prescaler
`timescale 1ns/1ps
module system_clock_prescaler_tb;
  import prescaler_pkg::*;
  localparam int LOCK_CYC = 50;
  localparam int FAST_CYC = 20;
  localparam int SLOW_CYC = 40;
  localparam int WD_CYC = 250000 / 128;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] addr_in = 8'h00;
  reg_byte_t wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  reg_byte_t rdata_out;
  logic [3:0] src_fuses = 4'h1;
  startup_code_t sut_fuses = SUT_SHORT;
  logic div8_fuse = 1'b0;
  logic cko_fuse = 1'b0;
  logic wake_req = 1'b0;
  logic gpio_d = 1'b0;
  logic gpio_oe = 1'b0;
  logic pin, pin_oe, sys_en, ext_sel, ready, wake_rdy, locked, fast_en;
  logic wd_tick;
  int mismatches = 0;
  int comparisons = 0;
  reg_byte_t rd_q[$];
  logic rd_seen = 1'b0;
  reg_byte_t cur;

  system_clock_prescaler #(
    .PLL_LOCK_CYCLES(LOCK_CYC),
    .SUT_FAST_CYCLES(FAST_CYC),
    .SUT_SLOW_CYCLES(SLOW_CYC)
  ) dut (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .wr_in(wr_in),
    .rd_in(rd_in),
    .rdata_out(rdata_out),
    .clock_source_fuses_in(src_fuses),
    .startup_time_fuses_in(sut_fuses),
    .start_divide_by_eight_fuse_in(div8_fuse),
    .clock_output_fuse_in(cko_fuse),
    .wake_request_in(wake_req),
    .gpio_data_in(gpio_d),
    .gpio_oe_in(gpio_oe),
    .clock_out_pin_out(pin),
    .clock_out_pin_oe_out(pin_oe),
    .sys_clock_enable_out(sys_en),
    .ext_clock_selected_out(ext_sel),
    .system_ready_out(ready),
    .wake_ready_out(wake_rdy),
    .pll_locked_flag_out(locked),
    .fast_clock_enable_out(fast_en),
    .watchdog_tick_out(wd_tick)
  );

  // master clock, 4 ns period
  always #2 mclk_in = ~mclk_in;

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %0h got %0h", nm, e, g);
    end
  endtask

  task automatic chk_rd(input reg_byte_t e, input reg_byte_t g);
    chk("rdata", {24'h0000_00, e}, {24'h0000_00, g});
  endtask

  // read answers are compared with the oldest noted value
  always @(posedge mclk_in) begin
    if (rd_seen && rd_q.size() > 0) begin
      chk_rd(rd_q.pop_front(), rdata_out);
    end
    rd_seen <= rd_in;
  end

  // one bus cycle, launched just after a rising edge
  task automatic cyc(input logic w, input logic r, input logic [7:0] a,
      input logic [7:0] d);
    @(posedge mclk_in);
    wr_in <= w;
    rd_in <= r;
    addr_in <= a;
    wdata_in <= d;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(1'b1, 1'b0, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input reg_byte_t e);
    rd_q.push_back(e);
    cyc(1'b0, 1'b1, a, 8'h00);
  endtask

  task automatic idle(input int n);
    repeat (n) cyc(1'b0, 1'b0, 8'h00, 8'h00);
  endtask

  // unlock then select on the next edge
  task automatic set_sel(input logic [3:0] s);
    wr(8'h00, 8'h80);
    wr(8'h00, {4'h0, s});
    idle(1);
    cur = {4'h0, s};
  endtask

  function automatic logic sv(input int w);
    case (w)
      0: sv = sys_en;
      1: sv = pin;
      default: sv = wd_tick;
    endcase
  endfunction

  // cycles until the watched signal next rises
  task automatic rise(input int w, output int k);
    logic p;
    logic r;
    k = 0;
    p = sv(w);
    do begin
      @(negedge mclk_in);
      k++;
      r = sv(w) & ~p;
      p = sv(w);
    end while (!r && k < 5000);
  endtask

  task automatic per(input int w, output int n);
    int k;
    rise(w, k);
    rise(w, n);
  endtask

  // reset with the given fuses, then check start-up delay and reset values
  task automatic do_reset(input startup_code_t s, input logic d8,
      input logic ck);
    int k;
    int x;
    @(posedge mclk_in);
    reset_in <= 1'b1;
    sut_fuses <= s;
    div8_fuse <= d8;
    cko_fuse <= ck;
    repeat (12) @(posedge mclk_in);
    @(negedge mclk_in);
    chk("pin_oe_rst", {31'd0, ck}, {31'd0, pin_oe});
    @(posedge mclk_in);
    reset_in <= 1'b0;
    k = 0;
    while (ready !== 1'b1 && k < 300) begin
      @(negedge mclk_in);
      k++;
    end
    x = (s == SUT_SHORT) ? 0 : (s == SUT_FAST) ? FAST_CYC : SLOW_CYC;
    chk("ready_min", 1, k >= 14 + x);
    chk("ready_max", 1, k <= 18 + x);
    cur = d8 ? 8'h03 : 8'h00;
    rd(8'h00, cur);
    rd(8'h01, 8'h00);
    idle(2);
  endtask

  // watchdog against a hang
  initial begin
    #200000;
    mismatches++;
    end_of_test();
  end

  initial begin
    int n;
    int k;
    int t1;
    logic [3:0] s;
    void'($urandom(32'h9d2e36cc));
    for (int i = 0; i < 4; i++) begin
      do_reset(startup_code_t'(i[1:0]), i[0], i[1]);
    end
    // factor one, then every factor up to 256
    set_sel(4'h0);
    idle(12);
    repeat (8) begin
      @(negedge mclk_in);
      chk("sys_en", 1, sys_en);
    end
    for (int c = 1; c <= 8; c++) begin
      t1 = 1 << (c - 1);
      set_sel(c[3:0]);
      per(0, n);
      chk("switch_min", 1, n >= t1);
      chk("switch_max", 1, n <= 5 * t1);
      per(0, n);
      chk("en_period", 2 * t1, n);
      per(1, n);
      chk("pin_period", 2 * t1, n);
    end
    // locked and unlocked writes to the divider register
    s = 4'($urandom_range(0, 7));
    wr(8'h00, {4'h0, s});
    idle(1);
    rd(8'h00, cur);
    wr(8'h00, 8'h80);
    idle(4);
    wr(8'h00, 8'h01);
    idle(1);
    rd(8'h00, cur);
    wr(8'h00, 8'h80);
    idle(3);
    wr(8'h00, 8'h02);
    idle(1);
    rd(8'h00, 8'h02);
    cur = 8'h02;
    wr(8'h00, 8'h80);
    idle(1);
    wr(8'h00, 8'h80);
    idle(2);
    wr(8'h00, 8'h05);
    idle(1);
    rd(8'h00, cur);
    wr(8'h00, 8'h80);
    wr(8'h00, 8'h80);
    rd(8'h00, 8'h82);
    wr(8'h00, 8'h01);
    idle(1);
    rd(8'h00, 8'h01);
    wr(8'h00, 8'h81);
    wr(8'h00, 8'h04);
    idle(1);
    rd(8'h00, 8'h01);
    wr(8'h00, 8'h80);
    wr(8'h00, 8'h72);
    idle(1);
    rd(8'h00, 8'h02);
    wr(8'h05, 8'hff);
    rd(8'h05, 8'h00);
    idle(1);
    // watchdog timebase
    per(2, n);
    chk("wd_period", WD_CYC, n);
    // source fuses
    for (int i = 0; i < 4; i++) begin
      s = (i == 0) ? 4'h0 : 4'($urandom_range(1, 15));
      @(posedge mclk_in);
      src_fuses <= s;
      idle(2);
      @(negedge mclk_in);
      chk("ext_sel", {31'd0, s == 4'h0}, {31'd0, ext_sel});
    end
    // wake delay
    @(posedge mclk_in);
    wake_req <= 1'b1;
    @(posedge mclk_in);
    wake_req <= 1'b0;
    k = 0;
    while (wake_rdy !== 1'b1 && k < 30) begin
      @(negedge mclk_in);
      k++;
    end
    chk("wake_min", 1, k >= 6);
    chk("wake_max", 1, k <= 10);
    // pll lock and fast clock gate
    wr(8'h01, 8'h04);
    idle(1);
    rd(8'h01, 8'h00);
    wr(8'h01, 8'h02);
    idle(1);
    k = 0;
    while (locked !== 1'b1 && k < 200) begin
      @(negedge mclk_in);
      k++;
    end
    chk("lock_min", 1, k >= LOCK_CYC - 2);
    chk("lock_max", 1, k <= LOCK_CYC + 4);
    wr(8'h01, 8'h06);
    idle(2);
    rd(8'h01, 8'h07);
    idle(1);
    @(negedge mclk_in);
    chk("fast_en", 1, fast_en);
    wr(8'h01, 8'h00);
    idle(3);
    @(negedge mclk_in);
    chk("unlocked", 0, {locked, fast_en});
    // fifth reset without the clock-output fuse: pin is plain i/o
    do_reset(SUT_SHORT, 1'b0, 1'b0);
    @(posedge mclk_in);
    gpio_d <= 1'($urandom);
    gpio_oe <= 1'b1;
    idle(2);
    @(negedge mclk_in);
    chk("gpio_pin", {gpio_oe, gpio_d}, {pin_oe, pin});
    idle(2);
    end_of_test();
  end
endmodule
